//--- src/dmsep_pkg.sv
/*
 * Constants shared by the dual-mode serial memory port: opcodes, chip address layout,
 * array and page geometry, reset values.
 * Assumes the serial master follows the two-wire or four-wire framing of its mode.
 */
package dmsep_pkg;
    // ========================================================================
    // array geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MEM_DEPTH = 256;
    localparam int unsigned PAGE_BYTES = 4;
    localparam int unsigned PAGE_IDX_W = 2;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    // ========================================================================
    // four-wire opcodes
    localparam logic [7:0] OP_READ = 8'ha7;
    localparam logic [7:0] OP_ENABLE = 8'ha6;
    localparam logic [7:0] OP_DISABLE = 8'ha4;
    localparam logic [7:0] OP_WRITE = 8'ha2;
    // ========================================================================
    // two-wire chip address byte: fixed nibble in [7:4], don't care [3],
    // select bits [2:1], direction [0]
    localparam logic [3:0] CHIP_FIXED = 4'ha;
    localparam int unsigned CHIP_FIXED_LSB = 4;
    localparam int unsigned CHIP_SEL_LSB = 1;
    localparam int unsigned CHIP_RW_BIT = 0;
    // bit slot: 8 data bits then one acknowledge bit
    localparam logic [3:0] SLOT_DATA_BITS = 4'h8;
    localparam logic [3:0] SLOT_LAST = 4'h9;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // ========================================================================
    // synchroniser vector layout
    localparam int unsigned SYNC_W = 9;
    localparam int unsigned SY_MODE = 8;
    localparam int unsigned SY_CSH = 7;
    localparam int unsigned SY_CSL = 6;
    localparam int unsigned SY_SCL = 5;
    localparam int unsigned SY_SDA = 4;
    localparam int unsigned SY_SCK = 3;
    localparam int unsigned SY_SSN = 2;
    localparam int unsigned SY_TGL = 1;
    localparam int unsigned SY_BIT = 0;

    typedef enum logic [1:0] {DMSEP_TW_IDLE, DMSEP_TW_RX, DMSEP_TW_TX} dmsep_tw_st_t;
    typedef enum logic [1:0] {DMSEP_K_CHIP, DMSEP_K_ADDR, DMSEP_K_DATA} dmsep_kind_t;
    typedef enum logic [2:0] {
        DMSEP_SP_OPC, DMSEP_SP_ADR, DMSEP_SP_WDAT, DMSEP_SP_RDAT, DMSEP_SP_IGN, DMSEP_SP_DEAD
    } dmsep_sp_st_t;
endpackage

//--- src/dmsep_top.sv
/*
 * Serial slave port of a 256-byte nonvolatile array with a two-wire open-drain mode and a
 * four-wire opcode mode, chosen by a strap. Programming is timed by the master; this block
 * raises program_voltage_out for that interval and commits latched bytes when it ends.
 * Assumes: ref_clk_in far faster than either serial clock; the four-wire clock only runs
 * while selected; select is high at power-up.
 */
// Function
// - two-wire: stop or start after data starts programming
// - only valid reselection ends two-wire programming
// - two-wire voltage on only during programming
// - four-byte pages, address advances per data byte
// - address increments as each transmitted byte is fetched
// - master nack releases data line, enter standby
// - start/stop detected from data edge, clock high
// - receiver acknowledges, transmitter releases data line
// - strap high selects four-wire mode
// - all bytes shifted most significant bit first
// - deselected: ignore input, output high impedance
// - first byte opcode: read or write
// - enable/disable opcodes drive latch and generator
// - invalid opcode: ignore until next select fall
// - sample rising edge, drive on falling edge
// - standby rules with select high
// - read: old address out, then data stream
// - write: old address out, echo new address
// - program needs enable and write, select high
// - read or invalid opcode drops pending data
// - select fall suspends; enable or read terminates
// - chip address 1010x plus two select pins
// - eighth bit sets transfer direction
// - byte after the chip address loads the byte address
// - receiver acks low; missing master ack stops
`timescale 1ns/1ps
module dmsep_top (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic mode_strap_in,
    input wire logic chip_select_bit_high_in,
    input wire logic chip_select_bit_low_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic four_wire_clock_in,
    input wire logic serial_select_n_in,
    input wire logic four_wire_data_in,
    output logic four_wire_data_out,
    output logic four_wire_data_oe_out,
    output logic program_voltage_out,
    output logic generator_on_out,
    output logic standby_out
);
    // ========================================================================
    // link domain: capture input bit on rising clock, flag it by toggle
    logic lk_tgl;
    logic lk_bit;
    // select high clears the link side; its clock may be stopped then
    always_ff @(posedge four_wire_clock_in or posedge serial_select_n_in) begin
        if (serial_select_n_in) begin
            lk_tgl <= 1'b0;
            lk_bit <= 1'b0;
        end else begin
            lk_tgl <= ~lk_tgl;
            lk_bit <= four_wire_data_in;
        end
    end

    // ========================================================================
    // synchronisers; stage one is read by stage two only
    logic [dmsep_pkg::SYNC_W-1:0] sy1, sy2, sy3;
    logic tgl_s4;
    wire [dmsep_pkg::SYNC_W-1:0] sy_raw = {mode_strap_in, chip_select_bit_high_in,
        chip_select_bit_low_in, scl_in, sda_in, four_wire_clock_in, serial_select_n_in,
        lk_tgl, lk_bit};
    always_ff @(posedge ref_clk_in) begin
        sy1 <= sy_raw;
        sy2 <= sy1;
        sy3 <= sy2;
        tgl_s4 <= sy3[dmsep_pkg::SY_TGL];
    end

    wire spi_mode = sy2[dmsep_pkg::SY_MODE];
    wire scl_rise = sy2[dmsep_pkg::SY_SCL] & ~sy3[dmsep_pkg::SY_SCL];
    wire scl_fall = ~sy2[dmsep_pkg::SY_SCL] & sy3[dmsep_pkg::SY_SCL];
    wire scl_hi = sy2[dmsep_pkg::SY_SCL] & sy3[dmsep_pkg::SY_SCL];
    wire sda_now = sy2[dmsep_pkg::SY_SDA];
    wire tw_start = !spi_mode && scl_hi && sy3[dmsep_pkg::SY_SDA] && !sda_now;
    wire tw_stop = !spi_mode && scl_hi && !sy3[dmsep_pkg::SY_SDA] && sda_now;
    wire sel = !sy2[dmsep_pkg::SY_SSN];
    wire sel_fall = spi_mode && sel && sy3[dmsep_pkg::SY_SSN];
    wire sck_fall = ~sy2[dmsep_pkg::SY_SCK] & sy3[dmsep_pkg::SY_SCK];
    // fourth toggle stage gives the captured bit time to settle in sy2
    wire bit_ev = spi_mode && sel && (sy3[dmsep_pkg::SY_TGL] ^ tgl_s4);
    wire bit_in = sy2[dmsep_pkg::SY_BIT];

    // ========================================================================
    // shared array, byte address and page latch
    logic [dmsep_pkg::DATA_W-1:0] mem [dmsep_pkg::MEM_DEPTH];
    logic [dmsep_pkg::ADDR_W-1:0] addr;
    logic [dmsep_pkg::DATA_W-1:0] pg_data [dmsep_pkg::PAGE_BYTES];
    logic [dmsep_pkg::PAGE_BYTES-1:0] pg_mask;
    logic [dmsep_pkg::ADDR_W-dmsep_pkg::PAGE_IDX_W-1:0] pg_base;
    logic addr_ld, addr_inc, pg_wr, pg_clr, commit;
    logic [dmsep_pkg::ADDR_W-1:0] addr_val;
    logic [dmsep_pkg::DATA_W-1:0] wr_data;
    wire [dmsep_pkg::DATA_W-1:0] mem_at_addr = mem[addr];
    wire [dmsep_pkg::PAGE_IDX_W-1:0] pg_idx = addr[dmsep_pkg::PAGE_IDX_W-1:0];

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            addr <= dmsep_pkg::ADDR_RESET;
            pg_mask <= '0;
            pg_base <= '0;
        end else begin
            if (addr_ld) begin
                // a read address load also steps past the byte it fetches
                addr <= addr_val + {7'h00, addr_inc};
            end else if (addr_inc) begin
                addr <= addr + 8'h01;
            end
            if (pg_clr) begin
                pg_mask <= '0;
            end else if (pg_wr) begin
                pg_mask[pg_idx] <= 1'b1;
                pg_base <= addr[dmsep_pkg::ADDR_W-1:dmsep_pkg::PAGE_IDX_W];
            end
        end
    end

    // latched bytes reach the array when the master-timed interval closes
    always_ff @(posedge ref_clk_in) begin
        if (pg_wr) begin
            pg_data[pg_idx] <= wr_data;
        end
        for (int i = 0; i < dmsep_pkg::PAGE_BYTES; i++) begin
            if (commit && pg_mask[i]) begin
                mem[{pg_base, i[dmsep_pkg::PAGE_IDX_W-1:0]}] <= pg_data[i];
            end
        end
    end

    // ========================================================================
    // two-wire engine
    dmsep_pkg::dmsep_tw_st_t tw_st;
    dmsep_pkg::dmsep_kind_t tw_kind;
    logic [3:0] tw_cnt;
    logic [7:0] tw_sr;
    logic [7:0] tw_tx;
    logic tw_oe, tw_wrote, tw_prog, tw_rd;

    wire tw_match = tw_sr[7:dmsep_pkg::CHIP_FIXED_LSB] == dmsep_pkg::CHIP_FIXED &&
        tw_sr[dmsep_pkg::CHIP_SEL_LSB+:2] == {sy2[dmsep_pkg::SY_CSH],
        sy2[dmsep_pkg::SY_CSL]};
    wire tw_ack = scl_fall && tw_st == dmsep_pkg::DMSEP_TW_RX &&
        tw_cnt == dmsep_pkg::SLOT_DATA_BITS;
    wire tw_sel_ok = tw_ack && tw_kind == dmsep_pkg::DMSEP_K_CHIP && tw_match;
    wire tw_slot_end = scl_fall && tw_st != dmsep_pkg::DMSEP_TW_IDLE &&
        tw_cnt == dmsep_pkg::SLOT_LAST;
    wire tw_load = tw_slot_end && tw_st == dmsep_pkg::DMSEP_TW_TX;
    wire tw_nack = scl_rise && tw_st == dmsep_pkg::DMSEP_TW_TX &&
        tw_cnt == dmsep_pkg::SLOT_DATA_BITS && sda_now;
    wire tw_addr_ld = tw_ack && tw_kind == dmsep_pkg::DMSEP_K_ADDR;
    wire tw_pg_wr = tw_ack && tw_kind == dmsep_pkg::DMSEP_K_DATA;

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in || spi_mode) begin
            tw_st <= dmsep_pkg::DMSEP_TW_IDLE;
            tw_kind <= dmsep_pkg::DMSEP_K_CHIP;
            tw_cnt <= 4'h0;
            tw_sr <= 8'h00;
            tw_tx <= 8'h00;
            tw_oe <= 1'b0;
            tw_wrote <= 1'b0;
            tw_prog <= 1'b0;
            tw_rd <= 1'b0;
        end else if (tw_start || tw_stop) begin
            tw_st <= tw_start ? dmsep_pkg::DMSEP_TW_RX : dmsep_pkg::DMSEP_TW_IDLE;
            tw_kind <= dmsep_pkg::DMSEP_K_CHIP;
            tw_cnt <= 4'h0;
            tw_oe <= 1'b0;
            tw_wrote <= 1'b0;
            if (tw_wrote) begin
                tw_prog <= 1'b1;
            end
        end else begin
            if (tw_sel_ok) begin
                tw_prog <= 1'b0;
            end
            if (tw_nack) begin
                tw_st <= dmsep_pkg::DMSEP_TW_IDLE;
            end else if (scl_rise && tw_st != dmsep_pkg::DMSEP_TW_IDLE) begin
                tw_cnt <= tw_cnt + 4'h1;
                if (tw_cnt < dmsep_pkg::SLOT_DATA_BITS) begin
                    tw_sr <= {tw_sr[6:0], sda_now};
                end
            end else if (tw_ack) begin
                tw_oe <= tw_kind != dmsep_pkg::DMSEP_K_CHIP || tw_match;
                if (tw_kind == dmsep_pkg::DMSEP_K_CHIP) begin
                    tw_rd <= tw_sr[dmsep_pkg::CHIP_RW_BIT];
                    tw_kind <= dmsep_pkg::DMSEP_K_ADDR;
                    if (!tw_match) begin
                        tw_st <= dmsep_pkg::DMSEP_TW_IDLE;
                    end else if (tw_sr[dmsep_pkg::CHIP_RW_BIT]) begin
                        tw_st <= dmsep_pkg::DMSEP_TW_TX;
                    end
                end else begin
                    tw_kind <= dmsep_pkg::DMSEP_K_DATA;
                end
                if (tw_pg_wr) begin
                    tw_wrote <= 1'b1;
                end
            end else if (tw_load) begin
                tw_cnt <= 4'h0;
                tw_tx <= mem_at_addr;
                tw_oe <= !mem_at_addr[7];
            end else if (tw_slot_end) begin
                tw_cnt <= 4'h0;
                tw_oe <= 1'b0;
            end else if (scl_fall && tw_st == dmsep_pkg::DMSEP_TW_TX) begin
                tw_tx <= {tw_tx[6:0], 1'b0};
                // master owns the ninth bit
                tw_oe <= tw_cnt < dmsep_pkg::SLOT_DATA_BITS && !tw_tx[6];
            end
        end
    end

    // ========================================================================
    // four-wire engine
    dmsep_pkg::dmsep_sp_st_t sp_st;
    logic [2:0] sp_cnt;
    logic [7:0] sp_sr;
    logic [7:0] so_sr;
    logic [7:0] so_next;
    logic so_ld, sp_rose, sp_rd, sp_en, sp_pend, sp_ran;
    wire [7:0] sp_byte = {sp_sr[6:0], bit_in};
    wire sp_done = bit_ev && sp_cnt == dmsep_pkg::BIT_LAST;
    wire sp_opc = sp_done && sp_st == dmsep_pkg::DMSEP_SP_OPC;
    wire op_rd = sp_opc && sp_byte == dmsep_pkg::OP_READ;
    wire op_wr = sp_opc && sp_byte == dmsep_pkg::OP_WRITE;
    wire op_en = sp_opc && sp_byte == dmsep_pkg::OP_ENABLE;
    wire op_dis = sp_opc && sp_byte == dmsep_pkg::OP_DISABLE;
    wire op_bad = sp_opc && !(op_rd || op_wr || op_en || op_dis);
    wire sp_adr = sp_done && sp_st == dmsep_pkg::DMSEP_SP_ADR;
    wire sp_wdat = sp_done && sp_st == dmsep_pkg::DMSEP_SP_WDAT;
    wire sp_rdat = sp_adr && sp_rd || sp_done && sp_st == dmsep_pkg::DMSEP_SP_RDAT;
    wire sp_prog = spi_mode && !sel && sp_en && sp_pend;
    // a finished program interval is closed by the next write, enable, read or invalid opcode
    wire sp_drop = op_rd || op_bad || op_wr || op_en && sp_ran;
    wire [7:0] sp_rd_data = sp_adr ? mem[sp_byte] : mem_at_addr;

    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in || !spi_mode) begin
            sp_st <= dmsep_pkg::DMSEP_SP_IGN;
            sp_cnt <= 3'h0;
            sp_sr <= 8'h00;
            so_sr <= 8'h00;
            so_next <= 8'h00;
            so_ld <= 1'b0;
            sp_rose <= 1'b0;
            sp_rd <= 1'b0;
            sp_en <= 1'b0;
            sp_pend <= 1'b0;
            sp_ran <= 1'b0;
        end else begin
            if (sp_prog) begin
                sp_ran <= 1'b1;
            end else if (sp_drop) begin
                sp_ran <= 1'b0;
            end
            if (op_en) begin
                sp_en <= 1'b1;
            end else if (op_dis) begin
                sp_en <= 1'b0;
            end
            if (sp_wdat) begin
                sp_pend <= 1'b1;
            end else if (sp_drop) begin
                sp_pend <= 1'b0;
            end
            if (sel_fall) begin
                sp_st <= dmsep_pkg::DMSEP_SP_OPC;
                sp_cnt <= 3'h0;
                so_sr <= addr;
                so_ld <= 1'b0;
                sp_rose <= 1'b0;
            end else begin
                if (bit_ev) begin
                    sp_cnt <= sp_cnt + 3'h1;
                    sp_sr <= sp_byte;
                    sp_rose <= 1'b1;
                end
                if (sp_done) begin
                    so_ld <= 1'b1;
                    so_next <= sp_rdat ? sp_rd_data : (sp_adr ? sp_byte : 8'h00);
                    if (op_rd || op_wr) begin
                        sp_st <= dmsep_pkg::DMSEP_SP_ADR;
                        sp_rd <= op_rd;
                    end else if (op_bad) begin
                        sp_st <= dmsep_pkg::DMSEP_SP_DEAD;
                    end else if (op_en || op_dis) begin
                        sp_st <= dmsep_pkg::DMSEP_SP_IGN;
                    end else if (sp_adr) begin
                        sp_st <= sp_rd ? dmsep_pkg::DMSEP_SP_RDAT : dmsep_pkg::DMSEP_SP_WDAT;
                    end
                end
                // past the select-fall load, output only moves on a falling edge that follows a sample
                if (sck_fall && sp_rose) begin
                    sp_rose <= 1'b0;
                    so_ld <= 1'b0;
                    so_sr <= so_ld ? so_next : {so_sr[6:0], 1'b0};
                end
            end
        end
    end

    // ========================================================================
    // mode selection of the shared resources
    assign addr_ld = spi_mode ? sp_adr : tw_addr_ld;
    assign addr_val = spi_mode ? sp_byte : tw_sr;
    assign addr_inc = spi_mode ? (sp_wdat || sp_rdat) : (tw_pg_wr || tw_load);
    assign pg_wr = spi_mode ? sp_wdat : tw_pg_wr;
    assign wr_data = spi_mode ? sp_byte : tw_sr;
    assign pg_clr = spi_mode ? sp_drop : tw_sel_ok;
    assign commit = spi_mode ? (sp_drop && sp_ran) : (tw_sel_ok && tw_prog);

    // ========================================================================
    // pins and status
    assign sda_out = 1'b0;
    assign sda_oe_out = tw_oe;
    assign four_wire_data_out = so_sr[7];
    assign four_wire_data_oe_out = spi_mode && sel &&
        sp_st != dmsep_pkg::DMSEP_SP_DEAD && sp_st != dmsep_pkg::DMSEP_SP_IGN;
    assign program_voltage_out = spi_mode ? sp_prog : tw_prog;
    assign generator_on_out = spi_mode ? sp_en : tw_prog;
    assign standby_out = spi_mode ? (!sel && !sp_en && !sp_pend) :
        (tw_st == dmsep_pkg::DMSEP_TW_IDLE && !tw_prog);

    // ========================================================================
    // checks
    a_prog_starts: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (tw_stop && tw_wrote && !spi_mode) |=> program_voltage_out)
        else $error("programming did not start after write close");
    a_prog_holds: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (tw_prog && !tw_sel_ok && !spi_mode && $stable(spi_mode)) |=> tw_prog)
        else $error("two-wire programming ended without valid reselection");
    a_nack_release: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        tw_nack |=> !sda_oe_out && tw_st == dmsep_pkg::DMSEP_TW_IDLE)
        else $error("data line held after master nack");
    a_ack_low: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (tw_ack && tw_kind == dmsep_pkg::DMSEP_K_DATA && !tw_start && !tw_stop)
        |=> sda_oe_out)
        else $error("data byte not acknowledged");
    a_desel_hiz: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (spi_mode && !sel) |-> !four_wire_data_oe_out)
        else $error("output driven while deselected");
    a_bad_quiet: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (op_bad && !sel_fall) |=> !four_wire_data_oe_out [*2])
        else $error("output driven after invalid opcode");
    a_enable_latch: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (op_en && spi_mode) |=> generator_on_out ##0 !standby_out)
        else $error("enable opcode did not start generator");
    a_prog_needs: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (spi_mode && program_voltage_out) |-> sp_en && sp_pend && !sel)
        else $error("program voltage without enable and pending write");
    a_read_drops: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (op_rd && !sel_fall) |=> !sp_pend)
        else $error("read opcode kept pending data");
    a_addr_step: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (addr_inc && !addr_ld) |=> addr == $past(addr) + 8'h01)
        else $error("byte address did not advance");
endmodule // dmsep_top

//--- bench/dmsep_master.sv
/*
 * Behavioural serial bus master for the dual-mode port: two-wire and four-wire tasks.
 * Assumes the bench resolves the open-drain data wire and feeds it back on sda_in.
 */
`timescale 1ns/1ps
module dmsep_master (
    output logic scl_out,
    output logic sda_out,
    output logic sck_out,
    output logic ssn_out,
    output logic mosi_out,
    input wire logic sda_in,
    input wire logic miso_in
);
    initial begin
        // four-wire clock idles low, so the first edge of a frame is a sampling edge
        {scl_out, sda_out, sck_out, ssn_out, mosi_out} = 5'h1a;
    end
    // ========================================================================
    // two-wire: data bits move only while the clock is low; start and stop move it with the clock high
    // data rises while the clock is still low, so a repeated start is not seen as a stop
    task automatic tw_start();
        #100 sda_out = 1'b1;
        #200 scl_out = 1'b1;
        #200 sda_out = 1'b0;
        #200 scl_out = 1'b0;
    endtask
    task automatic tw_stop();
        #50 sda_out = 1'b0;
        #200 scl_out = 1'b1;
        #200 sda_out = 1'b1;
        #200;
    endtask
    // rel_ack high leaves the ack slot released, i.e. a nack when reading
    task automatic tw_byte(input logic [7:0] tx, input logic rel_ack,
                           output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #50 sda_out = tx[i];
            #200 scl_out = 1'b1;
            #100 rx[i] = sda_in;
            #100 scl_out = 1'b0;
        end
        #50 sda_out = rel_ack;
        #200 scl_out = 1'b1;
        #100 ack = ~sda_in;
        #100 scl_out = 1'b0;
    endtask
    // ========================================================================
    // four-wire: clock stands still outside frames, 160 ns period inside
    task automatic fw_sel();
        ssn_out = 1'b0;
        #100;
    endtask
    task automatic fw_desel();
        #100 ssn_out = 1'b1;
        mosi_out = ~mosi_out; // released line does not keep its last value
        #200;
    endtask
    task automatic fw_xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi_out = tx[i];
            #80 sck_out = 1'b1;
            rx[i] = miso_in;
            #80 sck_out = 1'b0;
        end
    endtask
endmodule // dmsep_master

//--- bench/dmsep_top_bench.sv
/*
 * Self-checking bench for dmsep_top: two-wire write, reselect and reads, then four-wire
 * opcodes. Assumes the master model drives the serial pins and SDA has a pull-up.
 */
`timescale 1ns/1ps
module dmsep_top_bench;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic mode_strap_in = 1'b0;
    logic scl, sda_m, sck, ssn, mosi, sda_oe, sda_o, fw_do, fw_oe, pv, gen, stby;
    logic [7:0] r;
    logic a;
    int n_fail = 0;
    int checks_done = 0;
    wire sda_w = sda_m & ~(sda_oe & ~sda_o);
    wire miso = fw_oe ? fw_do : 1'bz;
    always #5 ref_clk_in = ~ref_clk_in;
    dmsep_top i_dmsep_top (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
        .mode_strap_in(mode_strap_in), .chip_select_bit_high_in(1'b1),
        .chip_select_bit_low_in(1'b0), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .four_wire_clock_in(sck), .serial_select_n_in(ssn),
        .four_wire_data_in(mosi), .four_wire_data_out(fw_do), .four_wire_data_oe_out(fw_oe),
        .program_voltage_out(pv), .generator_on_out(gen), .standby_out(stby));
    dmsep_master i_dmsep_master (.scl_out(scl), .sda_out(sda_m), .sck_out(sck),
        .ssn_out(ssn), .mosi_out(mosi), .sda_in(sda_w), .miso_in(miso));
    // ========================================================================
    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        cmp_byte(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #500000;
        n_fail++;
        tally_and_finish();
    end
    // ========================================================================
    initial begin
        tick(5);
        nrst_in = 1'b1;
        tick(5);
        i_dmsep_master.tw_start();
        i_dmsep_master.tw_byte(8'ha4, 1'b1, r, a);
        cmp_bit("chip ack", 1'b1, a);
        i_dmsep_master.tw_byte(8'h10, 1'b1, r, a);
        i_dmsep_master.tw_byte(8'h5a, 1'b1, r, a);
        i_dmsep_master.tw_byte(8'h5b, 1'b1, r, a);
        cmp_bit("data ack", 1'b1, a);
        i_dmsep_master.tw_stop();
        tick(5);
        cmp_bit("prog after stop", 1'b1, pv);
        i_dmsep_master.tw_start();
        i_dmsep_master.tw_byte(8'ha2, 1'b1, r, a);
        cmp_bit("foreign chip ack", 1'b0, a);
        i_dmsep_master.tw_stop();
        cmp_bit("prog kept", 1'b1, pv);
        i_dmsep_master.tw_start();
        i_dmsep_master.tw_byte(8'ha4, 1'b1, r, a);
        tick(5);
        cmp_bit("prog ended", 1'b0, pv);
        i_dmsep_master.tw_byte(8'h10, 1'b1, r, a);
        i_dmsep_master.tw_start();
        i_dmsep_master.tw_byte(8'ha5, 1'b1, r, a);
        cmp_bit("read chip ack", 1'b1, a);
        i_dmsep_master.tw_byte(8'hff, 1'b1, r, a);
        cmp_byte("read 0x10", 8'h5a, r);
        tick(5);
        cmp_bit("released after nack", 1'b0, sda_oe);
        i_dmsep_master.tw_stop();
        cmp_bit("standby after read", 1'b1, stby);
        i_dmsep_master.tw_start();
        i_dmsep_master.tw_byte(8'ha5, 1'b1, r, a);
        i_dmsep_master.tw_byte(8'hff, 1'b1, r, a);
        cmp_byte("sequential read", 8'h5b, r);
        i_dmsep_master.tw_stop();
        $display("two-wire test done");
        tick(1);
        mode_strap_in = 1'b1;
        tick(10);
        cmp_bit("two-wire idle", 1'b0, sda_oe);
        i_dmsep_master.fw_sel();
        i_dmsep_master.fw_xfer(8'ha7, r);
        cmp_byte("fw old address", 8'h12, r);
        i_dmsep_master.fw_xfer(8'h10, r);
        i_dmsep_master.fw_xfer(8'h00, r);
        cmp_byte("fw read 0x10", 8'h5a, r);
        i_dmsep_master.fw_xfer(8'h00, r);
        cmp_byte("fw read 0x11", 8'h5b, r);
        i_dmsep_master.fw_desel();
        cmp_bit("deselected oe", 1'b0, fw_oe);
        cmp_bit("standby read", 1'b1, stby);
        i_dmsep_master.fw_sel();
        i_dmsep_master.fw_xfer(8'h55, r);
        tick(5);
        cmp_bit("invalid opcode oe", 1'b0, fw_oe);
        i_dmsep_master.fw_desel();
        i_dmsep_master.fw_sel();
        i_dmsep_master.fw_xfer(8'ha6, r);
        i_dmsep_master.fw_desel();
        cmp_bit("generator on", 1'b1, gen);
        cmp_bit("no standby", 1'b0, stby);
        i_dmsep_master.fw_sel();
        i_dmsep_master.fw_xfer(8'ha4, r);
        i_dmsep_master.fw_desel();
        cmp_bit("generator off", 1'b0, gen);
        cmp_bit("standby disable", 1'b1, stby);
        i_dmsep_master.fw_sel();
        i_dmsep_master.fw_xfer(8'ha2, r);
        i_dmsep_master.fw_xfer(8'h20, r);
        i_dmsep_master.fw_xfer(8'h77, r);
        cmp_byte("address echo", 8'h20, r);
        i_dmsep_master.fw_desel();
        cmp_bit("write pending", 1'b0, stby);
        i_dmsep_master.fw_sel();
        i_dmsep_master.fw_xfer(8'ha6, r);
        i_dmsep_master.fw_desel();
        cmp_bit("fw programming", 1'b1, pv);
        i_dmsep_master.fw_sel();
        cmp_bit("suspended", 1'b0, pv);
        i_dmsep_master.fw_xfer(8'ha7, r);
        i_dmsep_master.fw_xfer(8'h20, r);
        i_dmsep_master.fw_xfer(8'h00, r);
        cmp_byte("programmed byte", 8'h77, r);
        i_dmsep_master.fw_desel();
        $display("four-wire test done");
        tally_and_finish();
    end
endmodule // dmsep_top_bench
